/* verilog/interrupt_and_event_transfer_unit.sv */
`timescale 1ns/1ps
// What this block does
// - accepted request reaches the core within about 8 clocks
// - each node chooses vectored interrupt or event transfer channel service
// - standard service presents the node's own vector to the core
// - channel service steals one cycle, no vector, no suspension
// - one byte or word moved, then source and/or destination pointer stepped
// - channel counter decrements per service except in continuous mode
// - counter reaching zero raises standard interrupt on the requesting node
// - eight independent event transfer channels
// - each node has control register with request, enable, priority
// - priority field gives sixteen levels
// - service preempted only by strictly higher priority or by a software vector call, which ignores level
// - fast external inputs detect rising, falling or both edges
// - software vector call with node number enters that node's service
// - software writing a node request bit to one raises a request
// - each fast external input selects alternate pin A or B
module interrupt_and_event_transfer_unit
    import ietu_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [NODES-1:0] i_src_req,
    input wire logic i_fast_ext_irq_input_2_a,
    input wire logic i_fast_ext_irq_input_2_b,
    input wire logic i_fast_ext_irq_input_3_a,
    input wire logic i_fast_ext_irq_input_3_b,
    input wire logic i_trap_valid,
    input wire logic [NODE_W-1:0] i_trap_num,
    output logic o_irq_req,
    output logic [NODE_W-1:0] o_irq_node,
    output logic [PRIO_W-1:0] o_irq_prio,
    output logic o_irq_trap,
    input wire logic i_irq_ack,
    input wire logic i_irq_done,
    output logic o_xfer_req,
    output logic [CHAN_W-1:0] o_xfer_chan,
    output logic [PTR_W-1:0] o_xfer_src,
    output logic [PTR_W-1:0] o_xfer_dst,
    output logic o_xfer_word,
    input wire logic i_xfer_ack
);
    typedef enum logic [1:0] {ST_IDLE, ST_IRQ, ST_XFER} deliv_state_t;
    localparam int RESP_MAX = RESP_CYCLES;

    deliv_state_t state_q;
    logic [NODES-1:0] req_q, en_q, chmode_q, isr_q;
    logic [PRIO_W-1:0] prio_q [NODES];
    logic [CHAN_W-1:0] chsel_q [NODES];
    logic [PTR_W-1:0] src_q [CHANS];
    logic [PTR_W-1:0] dst_q [CHANS];
    logic [CNT_W-1:0] cnt_q [CHANS];
    logic [3:0] cctl_q [CHANS];
    logic [5:0] xcfg_q;
    logic trap_pend_q;
    logic [NODE_W-1:0] trap_num_q, xfer_node_q;
    logic fast2_edge, fast3_edge;
    logic [NODES-1:0] hw_req;

    // apb decode
    logic apb_access, apb_wr, apb_rd;
    logic node_hit, chan_hit, xcfg_hit, stat_hit;
    logic [NODE_W-1:0] wr_node;
    logic [CHAN_W-1:0] wr_chan;
    logic [1:0] wr_sub;
    logic [31:0] rd_val;

    assign apb_access = i_psel && i_penable && o_pready;
    assign apb_wr = apb_access && i_pwrite;
    assign apb_rd = i_psel && i_penable && !o_pready && !i_pwrite;
    assign wr_node = i_paddr[5:2];
    assign wr_chan = i_paddr[6:4];
    assign wr_sub = i_paddr[3:2];

    // address decode
    always_comb begin
        node_hit = 1'b0;
        chan_hit = 1'b0;
        xcfg_hit = 1'b0;
        stat_hit = 1'b0;
        if (i_paddr[1:0] != 2'h0) begin
            node_hit = 1'b0;
        end else if (i_paddr[11:8] == NODE_PAGE && i_paddr[7:6] == 2'h0) begin
            node_hit = 1'b1;
        end else if (i_paddr[11:8] == CHAN_PAGE && !i_paddr[7]) begin
            chan_hit = 1'b1;
        end else if (i_paddr == EXT_CFG_ADDR) begin
            xcfg_hit = 1'b1;
        end else if (i_paddr == STATUS_ADDR) begin
            stat_hit = 1'b1;
        end
    end

    // read mux
    always_comb begin
        rd_val = 32'h0000_0000;
        if (node_hit) begin
            rd_val[NF_REQ] = req_q[wr_node];
            rd_val[NF_EN] = en_q[wr_node];
            rd_val[NF_PRIO +: PRIO_W] = prio_q[wr_node];
            rd_val[NF_CHMODE] = chmode_q[wr_node];
            rd_val[NF_CHSEL +: CHAN_W] = chsel_q[wr_node];
        end else if (chan_hit) begin
            case (wr_sub)
                CH_SRC: rd_val[PTR_W-1:0] = src_q[wr_chan];
                CH_DST: rd_val[PTR_W-1:0] = dst_q[wr_chan];
                CH_CNT: rd_val[CNT_W-1:0] = cnt_q[wr_chan];
                default: rd_val[3:0] = cctl_q[wr_chan];
            endcase
        end else if (xcfg_hit) begin
            rd_val[5:0] = xcfg_q;
        end else if (stat_hit) begin
            rd_val[NODES-1:0] = isr_q;
            rd_val[NODES] = trap_pend_q;
        end
    end

    // apb answer one cycle into the access phase
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0000_0000;
        end else begin
            o_pready <= i_psel && i_penable && !o_pready;
            o_pslverr <= i_psel && i_penable && !o_pready && !(node_hit || chan_hit || xcfg_hit || stat_hit);
            o_prdata <= apb_rd ? rd_val : 32'h0000_0000;
        end
    end

    // fast external inputs
    fast_edge_detect u_fast2 (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_pin_a(i_fast_ext_irq_input_2_a),
        .i_pin_b(i_fast_ext_irq_input_2_b),
        .i_sel_b(xcfg_q[XF2_SEL]),
        .i_mode(xcfg_q[XF2_MODE +: 2]),
        .o_edge(fast2_edge)
    );
    fast_edge_detect u_fast3 (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_pin_a(i_fast_ext_irq_input_3_a),
        .i_pin_b(i_fast_ext_irq_input_3_b),
        .i_sel_b(xcfg_q[XF3_SEL]),
        .i_mode(xcfg_q[XF3_MODE +: 2]),
        .o_edge(fast3_edge)
    );

    always_comb begin
        hw_req = i_src_req;
        hw_req[FAST2_NODE] = i_src_req[FAST2_NODE] || fast2_edge;
        hw_req[FAST3_NODE] = i_src_req[FAST3_NODE] || fast3_edge;
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            xcfg_q <= XCFG_RST;
        end else if (apb_wr && xcfg_hit) begin
            xcfg_q <= i_pwdata[5:0];
        end
    end

    // arbitration: highest level, lowest index on a tie
    logic best_vld;
    logic [NODE_W-1:0] best_idx;
    logic [PRIO_W-1:0] best_prio;
    logic [CHAN_W-1:0] best_chan;
    logic best_xfer, best_ok;
    logic [PRIO_W:0] cur_lvl;

    always_comb begin
        best_vld = 1'b0;
        best_idx = '0;
        best_prio = '0;
        for (int i = 0; i < NODES; i++) begin
            if (req_q[i] && en_q[i] && (!best_vld || prio_q[i] > best_prio)) begin
                best_vld = 1'b1;
                best_idx = NODE_W'(i);
                best_prio = prio_q[i];
            end
        end
    end

    // current level: highest level in service, zero when none
    always_comb begin
        cur_lvl = '0;
        for (int l = 0; l < NODES; l++) begin
            if (isr_q[l]) begin
                cur_lvl = {1'b1, PRIO_W'(l)};
            end
        end
    end

    assign best_chan = chsel_q[best_idx];
    assign best_xfer = chmode_q[best_idx] && (cnt_q[best_chan] != CNT_RST || cctl_q[best_chan][CF_CONT]);
    assign best_ok = best_vld && ({1'b1, best_prio} > cur_lvl);

    logic irq_fire, xfer_fire, sel_cont, sel_word;
    logic [CNT_W-1:0] sel_cnt;
    assign irq_fire = (state_q == ST_IRQ) && i_irq_ack;
    assign xfer_fire = (state_q == ST_XFER) && i_xfer_ack;
    assign sel_cnt = cnt_q[o_xfer_chan];
    assign sel_cont = cctl_q[o_xfer_chan][CF_CONT];
    assign sel_word = cctl_q[o_xfer_chan][CF_WORD];

    // delivery to the core
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= ST_IDLE;
            o_irq_req <= 1'b0;
            o_irq_node <= '0;
            o_irq_prio <= '0;
            o_irq_trap <= 1'b0;
            o_xfer_req <= 1'b0;
            o_xfer_chan <= '0;
            o_xfer_src <= PTR_RST;
            o_xfer_dst <= PTR_RST;
            o_xfer_word <= 1'b0;
            xfer_node_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (trap_pend_q) begin
                        state_q <= ST_IRQ;
                        o_irq_req <= 1'b1;
                        o_irq_trap <= 1'b1;
                        o_irq_node <= trap_num_q;
                        o_irq_prio <= prio_q[trap_num_q];
                    end else if (best_ok && best_xfer) begin
                        state_q <= ST_XFER;
                        o_xfer_req <= 1'b1;
                        o_xfer_chan <= best_chan;
                        o_xfer_src <= src_q[best_chan];
                        o_xfer_dst <= dst_q[best_chan];
                        o_xfer_word <= cctl_q[best_chan][CF_WORD];
                        xfer_node_q <= best_idx;
                    end else if (best_ok) begin
                        state_q <= ST_IRQ;
                        o_irq_req <= 1'b1;
                        o_irq_trap <= 1'b0;
                        o_irq_node <= best_idx;
                        o_irq_prio <= best_prio;
                    end
                end
                ST_IRQ: begin
                    if (i_irq_ack) begin
                        state_q <= ST_IDLE;
                        o_irq_req <= 1'b0;
                    end
                end
                default: begin
                    if (i_xfer_ack) begin
                        state_q <= ST_IDLE;
                        o_xfer_req <= 1'b0;
                    end
                end
            endcase
        end
    end

    // levels in service; done retires the highest
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            isr_q <= '0;
        end else begin
            for (int l = 0; l < NODES; l++) begin
                if (irq_fire && !o_irq_trap && o_irq_prio == PRIO_W'(l)) begin
                    isr_q[l] <= 1'b1;
                end else if (i_irq_done && cur_lvl == {1'b1, PRIO_W'(l)}) begin
                    isr_q[l] <= 1'b0;
                end
            end
        end
    end

    // pending software vector call
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            trap_pend_q <= 1'b0;
            trap_num_q <= '0;
        end else if (i_trap_valid && (!trap_pend_q || irq_fire && o_irq_trap)) begin
            trap_pend_q <= 1'b1;
            trap_num_q <= i_trap_num;
        end else if (irq_fire && o_irq_trap) begin
            trap_pend_q <= 1'b0;
        end
    end

    // per-node control registers
    genvar gn;
    generate
        for (gn = 0; gn < NODES; gn++) begin : g_node
            logic wr_hit, set_req, clr_req;
            assign wr_hit = apb_wr && node_hit && wr_node == NODE_W'(gn);
            assign set_req = hw_req[gn] || (wr_hit && i_pwdata[NF_REQ])
                || (xfer_fire && xfer_node_q == NODE_W'(gn) && !sel_cont && sel_cnt == 8'h01);
            assign clr_req = (wr_hit && !i_pwdata[NF_REQ])
                || (irq_fire && !o_irq_trap && o_irq_node == NODE_W'(gn))
                || (xfer_fire && xfer_node_q == NODE_W'(gn));
            always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    req_q[gn] <= 1'b0;
                end else if (set_req) begin
                    req_q[gn] <= 1'b1;
                end else if (clr_req) begin
                    req_q[gn] <= 1'b0;
                end
            end
            always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    en_q[gn] <= 1'b0;
                    prio_q[gn] <= '0;
                    chmode_q[gn] <= 1'b0;
                    chsel_q[gn] <= '0;
                end else if (wr_hit) begin
                    en_q[gn] <= i_pwdata[NF_EN];
                    prio_q[gn] <= i_pwdata[NF_PRIO +: PRIO_W];
                    chmode_q[gn] <= i_pwdata[NF_CHMODE];
                    chsel_q[gn] <= i_pwdata[NF_CHSEL +: CHAN_W];
                end
            end
        end
    endgenerate

    // event transfer channels
    genvar gc;
    generate
        for (gc = 0; gc < CHANS; gc++) begin : g_chan
            logic wr_hit, svc;
            logic [PTR_W-1:0] step;
            assign wr_hit = apb_wr && chan_hit && wr_chan == CHAN_W'(gc);
            assign svc = xfer_fire && o_xfer_chan == CHAN_W'(gc);
            assign step = cctl_q[gc][CF_WORD] ? STEP_WORD : STEP_BYTE;
            always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    src_q[gc] <= PTR_RST;
                    dst_q[gc] <= PTR_RST;
                    cnt_q[gc] <= CNT_RST;
                    cctl_q[gc] <= 4'h0;
                end else if (wr_hit) begin
                    if (wr_sub == CH_SRC) src_q[gc] <= i_pwdata[PTR_W-1:0];
                    if (wr_sub == CH_DST) dst_q[gc] <= i_pwdata[PTR_W-1:0];
                    if (wr_sub == CH_CNT) cnt_q[gc] <= i_pwdata[CNT_W-1:0];
                    if (wr_sub == CH_CTRL) cctl_q[gc] <= i_pwdata[3:0];
                end else if (svc) begin
                    if (cctl_q[gc][CF_INC_SRC]) src_q[gc] <= src_q[gc] + step;
                    if (cctl_q[gc][CF_INC_DST]) dst_q[gc] <= dst_q[gc] + step;
                    if (!cctl_q[gc][CF_CONT]) cnt_q[gc] <= cnt_q[gc] - 8'h01;
                end
            end
        end
    endgenerate

    AST_RESP_TIME: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (state_q == ST_IDLE && best_ok) |-> ##[1:RESP_MAX] (o_irq_req || o_xfer_req))
        else $error("request not delivered in time");
    AST_STEAL_ONE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        xfer_fire |=> !o_xfer_req && !o_irq_req && !isr_q[$past(best_prio)] == !$past(isr_q[best_prio]))
        else $error("transfer service did more than one stolen cycle");
    AST_CNT_DEC: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (xfer_fire && !apb_wr) |=> cnt_q[$past(o_xfer_chan)] ==
            ($past(sel_cont) ? $past(sel_cnt) : $past(sel_cnt) - 8'h01))
        else $error("transfer counter step wrong");
    AST_SRC_STEP: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (xfer_fire && !apb_wr && cctl_q[o_xfer_chan][CF_INC_SRC]) |=> src_q[$past(o_xfer_chan)] ==
            $past(o_xfer_src) + ($past(sel_word) ? STEP_WORD : STEP_BYTE))
        else $error("source pointer not stepped");
    AST_ZERO_REARM: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (xfer_fire && !sel_cont && sel_cnt == 8'h01) |=> req_q[$past(xfer_node_q)] ##1
            (state_q == ST_IRQ || !en_q[$past(xfer_node_q, 2)] || !best_ok || trap_pend_q || o_xfer_req))
        else $error("zero count did not raise standard interrupt");
    AST_PREEMPT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (o_irq_req && !o_irq_trap) |-> ({1'b1, o_irq_prio} > cur_lvl))
        else $error("service offered at or below current level");
    AST_ACK_CLEAR: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (irq_fire && !o_irq_trap && !hw_req[o_irq_node] && !apb_wr) |=> !req_q[$past(o_irq_node)])
        else $error("accepted request flag not cleared");
    AST_SW_SET: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (apb_wr && node_hit && i_pwdata[NF_REQ]) |=> req_q[$past(wr_node)])
        else $error("software request bit write lost");
    AST_TRAP_ENTRY: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (i_trap_valid && !trap_pend_q && state_q == ST_IDLE) |-> ##[1:3] (o_irq_req && o_irq_trap))
        else $error("software vector call not entered");
endmodule

/* common/ietu_pkg.sv */
package ietu_pkg;
    // sizes
    localparam int NODES = 16;
    localparam int NODE_W = 4;
    localparam int CHANS = 8;
    localparam int CHAN_W = 3;
    localparam int PRIO_W = 4;
    localparam int PTR_W = 16;
    localparam int CNT_W = 8;
    localparam int ADDR_W = 12;
    // delivery bound in cpu clocks
    localparam int RESP_CYCLES = 8;
    // register map, byte addresses
    localparam logic [3:0] NODE_PAGE = 4'h0;
    localparam logic [3:0] CHAN_PAGE = 4'h1;
    localparam logic [ADDR_W-1:0] EXT_CFG_ADDR = 12'h200;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h204;
    // channel word index within a 16-byte block
    localparam logic [1:0] CH_SRC = 2'h0;
    localparam logic [1:0] CH_DST = 2'h1;
    localparam logic [1:0] CH_CNT = 2'h2;
    localparam logic [1:0] CH_CTRL = 2'h3;
    // node control fields
    localparam int NF_REQ = 0;
    localparam int NF_EN = 1;
    localparam int NF_PRIO = 2;
    localparam int NF_CHMODE = 6;
    localparam int NF_CHSEL = 7;
    // channel control fields
    localparam int CF_INC_SRC = 0;
    localparam int CF_INC_DST = 1;
    localparam int CF_WORD = 2;
    localparam int CF_CONT = 3;
    // fast input config fields
    localparam int XF2_MODE = 0;
    localparam int XF2_SEL = 2;
    localparam int XF3_MODE = 3;
    localparam int XF3_SEL = 5;
    // edge modes
    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // nodes fed by the fast inputs
    localparam int FAST2_NODE = 14;
    localparam int FAST3_NODE = 15;
    // pointer steps
    localparam logic [PTR_W-1:0] STEP_BYTE = 16'h0001;
    localparam logic [PTR_W-1:0] STEP_WORD = 16'h0002;
    // reset values
    localparam logic [PTR_W-1:0] PTR_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
    localparam logic [5:0] XCFG_RST = 6'h00;
endpackage

/* verilog/fast_edge_detect.sv */
`timescale 1ns/1ps
module fast_edge_detect
    import ietu_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_pin_a,
    input wire logic i_pin_b,
    input wire logic i_sel_b,
    input wire logic [1:0] i_mode,
    output logic o_edge
);
    logic a_s1_q, a_s2_q, b_s1_q, b_s2_q, lvl_q;
    logic pin_lvl, rise, fall;

    // two-stage synchronisers for both alternate pins
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            a_s1_q <= 1'b0;
            a_s2_q <= 1'b0;
            b_s1_q <= 1'b0;
            b_s2_q <= 1'b0;
        end else begin
            a_s1_q <= i_pin_a;
            a_s2_q <= a_s1_q;
            b_s1_q <= i_pin_b;
            b_s2_q <= b_s1_q;
        end
    end

    // pin choice and edge qualification
    assign pin_lvl = i_sel_b ? b_s2_q : a_s2_q;
    assign rise = pin_lvl && !lvl_q;
    assign fall = !pin_lvl && lvl_q;

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            lvl_q <= 1'b0;
            o_edge <= 1'b0;
        end else begin
            lvl_q <= pin_lvl;
            o_edge <= (rise && i_mode[0]) || (fall && i_mode[1]);
        end
    end

    AST_EDGE_RISE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (rise && i_mode == EDGE_RISE) |=> o_edge)
        else $error("rising edge not flagged");
    AST_EDGE_FALL_ONLY: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (rise && i_mode == EDGE_FALL) |=> !o_edge)
        else $error("rising edge flagged in falling mode");
endmodule

/* tb/core_model.sv */
`timescale 1ns/1ps
module core_model (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_irq_req,
    input wire logic i_xfer_req,
    input wire logic i_ret,
    input wire logic [2:0] i_delay,
    output logic o_irq_ack,
    output logic o_irq_done,
    output logic o_xfer_ack
);
    logic [2:0] wait_q;
    // accept an offered service after a chosen delay
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wait_q <= 3'h0;
            o_irq_ack <= 1'b0;
        end else if (i_irq_req && !o_irq_ack && wait_q != i_delay) begin
            wait_q <= wait_q + 3'h1;
        end else begin
            o_irq_ack <= i_irq_req && !o_irq_ack;
            wait_q <= 3'h0;
        end
    end
    // stolen cycle granted at once, return on request
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_xfer_ack <= 1'b0;
            o_irq_done <= 1'b0;
        end else begin
            o_xfer_ack <= i_xfer_req && !o_xfer_ack;
            o_irq_done <= i_ret;
        end
    end
endmodule

/* tb/interrupt_and_event_transfer_unit_test.sv */
`timescale 1ns/1ps
module interrupt_and_event_transfer_unit_test;
    import ietu_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, trap_v = 1'b0, ret = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, irq_req, irq_trap, ack, done, xreq, xword, xack;
    logic [15:0] src_req = 16'h0, xsrc, xdst;
    logic [3:0] pins = 4'h4, trap_n = 4'h0, irq_node, irq_prio;
    logic [2:0] delay = 3'h0, xchan;
    int num_errors = 0, num_checks = 0;
    always #12.5 clk = ~clk;
    interrupt_and_event_transfer_unit uut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_src_req(src_req), .i_fast_ext_irq_input_2_a(pins[0]),
        .i_fast_ext_irq_input_2_b(pins[1]), .i_fast_ext_irq_input_3_a(pins[2]), .i_fast_ext_irq_input_3_b(pins[3]),
        .i_trap_valid(trap_v), .i_trap_num(trap_n), .o_irq_req(irq_req), .o_irq_node(irq_node),
        .o_irq_prio(irq_prio), .o_irq_trap(irq_trap), .i_irq_ack(ack), .i_irq_done(done), .o_xfer_req(xreq),
        .o_xfer_chan(xchan), .o_xfer_src(xsrc), .o_xfer_dst(xdst), .o_xfer_word(xword), .i_xfer_ack(xack));
    core_model core (.i_sys_clk(clk), .i_rst_b(rst_b), .i_irq_req(irq_req), .i_xfer_req(xreq), .i_ret(ret),
        .i_delay(delay), .o_irq_ack(ack), .o_irq_done(done), .o_xfer_ack(xack));
    task automatic print_verdict();
        if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // bounded wait for pready, irq request or transfer request
    task automatic wait_for(input int sel, input logic lvl, output int n);
        logic h;
        n = 0;
        h = 1'b0;
        while (!h) begin
            @(posedge clk);
            #1;
            n++;
            h = ((sel == 0) ? pready : (sel == 1) ? irq_req : xreq) === lvl;
            if (n > 60) begin
                check("wait", 32'h1, 32'h0);
                print_verdict();
            end
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] x,
        input logic err);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        wait_for(0, 1'b1, n);
        // answer taken at the edge that samples pready high
        @(posedge clk);
        if (!w) check("rdata", x, prdata);
        check("slverr", 32'(err), 32'(pslverr));
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, a[9] && a[8]);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, x, a[9] && a[8]);
    endtask
    task automatic expect_irq(input logic [3:0] node, input logic [3:0] prio, input logic trap);
        int n;
        wait_for(1, 1'b1, n);
        check("irq_node", 32'(node), 32'(irq_node));
        check("irq_trap", 32'(trap), 32'(irq_trap));
        if (!trap) check("irq_prio", 32'(prio), 32'(irq_prio));
        check("latency", 32'h1, 32'(n <= RESP_CYCLES));
        wait_for(1, 1'b0, n);
        @(posedge clk);
    endtask
    task automatic expect_xfer(input logic [2:0] ch, input logic [15:0] s, input logic [15:0] d, input logic w);
        int n;
        wait_for(2, 1'b1, n);
        check("xfer_chan", 32'(ch), 32'(xchan));
        check("xfer_src", 32'(s), 32'(xsrc));
        check("xfer_dst", 32'(d), 32'(xdst));
        check("xfer_word", 32'(w), 32'(xword));
        check("no_vector", 32'h0, 32'(irq_req));
        wait_for(2, 1'b0, n);
        @(posedge clk);
    endtask
    task automatic pulse(input logic [15:0] m);
        src_req <= m;
        @(posedge clk);
        src_req <= 16'h0;
    endtask
    task automatic finish_svc();
        ret <= 1'b1;
        @(posedge clk);
        ret <= 1'b0;
        @(posedge clk);
    endtask
    // main sequence
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(12'h00c, 32'h0);
        wr(12'h300, 32'hffff_ffff);
        rd(12'h300, 32'h0);
        wr(12'h00c, 32'h17);
        expect_irq(4'h3, 4'h5, 1'b0);
        rd(12'h00c, 32'h16);
        rd(12'h204, 32'h20);
        wr(12'h010, 32'h17);
        wr(12'h018, 32'h1b);
        expect_irq(4'h6, 4'h6, 1'b0);
        finish_svc();
        finish_svc();
        expect_irq(4'h4, 4'h5, 1'b0);
        finish_svc();
        delay <= 3'h3;
        wr(12'h008, 32'h3e);
        wr(12'h014, 32'h1e);
        pulse(16'h0024);
        expect_irq(4'h2, 4'hf, 1'b0);
        finish_svc();
        expect_irq(4'h5, 4'h7, 1'b0);
        finish_svc();
        wr(12'h170, 32'h10);
        wr(12'h174, 32'h20);
        wr(12'h178, 32'h2);
        wr(12'h17c, 32'h5);
        wr(12'h004, 32'h3c6);
        pulse(16'h0002);
        expect_xfer(3'h7, 16'h10, 16'h20, 1'b1);
        pulse(16'h0002);
        expect_xfer(3'h7, 16'h12, 16'h20, 1'b1);
        expect_irq(4'h1, 4'h1, 1'b0);
        finish_svc();
        rd(12'h178, 32'h0);
        wr(12'h100, 32'h40);
        wr(12'h104, 32'h50);
        wr(12'h108, 32'h3);
        wr(12'h10c, 32'ha);
        wr(12'h000, 32'h46);
        pulse(16'h0001);
        expect_xfer(3'h0, 16'h40, 16'h50, 1'b0);
        rd(12'h108, 32'h3);
        rd(12'h104, 32'h51);
        rd(12'h100, 32'h40);
        trap_n <= 4'h9;
        trap_v <= 1'b1;
        @(posedge clk);
        trap_v <= 1'b0;
        expect_irq(4'h9, 4'h0, 1'b1);
        wr(12'h038, 32'h0a);
        wr(12'h03c, 32'h0a);
        wr(12'h200, 32'h05);
        pins[0] <= 1'b1;
        repeat (8) @(posedge clk);
        check("pin_a_ignored", 32'h0, 32'(irq_req));
        pins[1] <= 1'b1;
        expect_irq(4'he, 4'h2, 1'b0);
        finish_svc();
        wr(12'h200, 32'h10);
        pins[2] <= 1'b0;
        expect_irq(4'hf, 4'h2, 1'b0);
        finish_svc();
        pins[2] <= 1'b1;
        repeat (8) @(posedge clk);
        check("rise_in_fall_mode", 32'h0, 32'(irq_req));
        wr(12'h200, 32'h03);
        pins[0] <= 1'b0;
        expect_irq(4'he, 4'h2, 1'b0);
        print_verdict();
    end
endmodule
